// ---- test/ebsc_mem_model.sv ----
// Behavioural external memory side: measures every chip select burst
module ebsc_mem_model
   import ebsc_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] chip_sel_n,
   output logic [2:0] last_rgn,
   output logic [3:0] last_len,
   output logic [7:0] sel_count
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] run_q = 4'h0;
   initial begin
      last_rgn = 3'h0;
      last_len = 4'h0;
      sel_count = 8'h0;
   end
   // The memory only listens; it has no data lines towards this block
   always @(posedge clk) begin
      if (~&chip_sel_n) begin
         run_q <= run_q + 4'h1;
         for (int i = 0; i < 8; i++)
            if (!chip_sel_n[i]) last_rgn <= 3'(i);
      end else if (run_q != 4'h0) begin
         last_len <= run_q;
         sel_count <= sel_count + 8'h1;
         run_q <= 4'h0;
      end
   end
endmodule // ebsc_mem_model

// ---- test/ebsc_top_monitor.sv ----
// Checker of chip select, remap and register port behaviour
module ebsc_top_monitor
   import ebsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic boot_8bit,
   input wire logic [ebsc_addr_w-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic acc_req,
   input wire logic acc_busy,
   input wire logic [7:0] chip_sel_n,
   input wire logic boot_remap_on,
   input wire logic read_early,
   input wire logic bus16,
   input wire logic bus8,
   input wire logic access_miss
);
   // Shadow of region settings rebuilt from writes, so lengths are known
   logic [31:0] sh_q [8];
   logic [31:0] sh_d [8];
   logic [3:0] cnt_q, cnt_d, exp_len;
   logic [2:0] idx_q, idx_d;
   logic [7:0] son;
   logic wr_rgn, wr_ctl;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   assign wr_rgn = reg_wr && reg_addr < ebsc_off_remap && reg_addr[1:0] == 2'h0;
   assign wr_ctl = reg_wr && reg_addr == ebsc_off_memctl;
   always_comb begin
      sh_d = sh_q;
      cnt_d = &chip_sel_n ? 4'h0 : cnt_q + 4'h1;
      idx_d = idx_q;
      for (int i = 0; i < 8; i++) begin
         son[i] = sh_q[i][ebsc_so_bit];
         if (!chip_sel_n[i]) idx_d = 3'(i);
      end
      if (wr_rgn) sh_d[reg_addr[4:2]] = reg_wdata & ebsc_region_mask;
      exp_len = sh_q[idx_q][ebsc_wg_bit] ? {1'b0, sh_q[idx_q][ebsc_wc_lo +: 3]} + 4'h2 : 4'h1;
      if (reset) begin
         for (int i = 1; i < 8; i++) sh_d[i] = 32'(ebsc_region_rst_step * i);
         sh_d[0] = boot_8bit ? ebsc_region0_rst_8 : ebsc_region0_rst_16;
         cnt_d = 4'h0;
      end
   end
   always_ff @(posedge clk) begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
   end
   // ****************************************
   // Assertions
   // ****************************************
   a_cs_needs_on: assert property ((~chip_sel_n & ~son) == 8'h00)
      else $error("chip select active on a disabled region");
   a_one_select: assert property ($onehot0(~chip_sel_n))
      else $error("more than one chip select active");
   a_select_length: assert property (&chip_sel_n && cnt_q != 4'h0 |-> cnt_q == exp_len)
      else $error("chip select length differs from wait setting");
   a_remap_cancel: assert property (reg_wr && reg_addr == ebsc_off_remap && reg_wdata[0]
      |=> !boot_remap_on) else $error("remap not cancelled");
   a_remap_zero_kept: assert property (reg_wr && reg_addr == ebsc_off_remap && !reg_wdata[0]
      |=> $stable(boot_remap_on)) else $error("remap changed by a zero write");
   a_early_source: assert property ($changed(read_early) |-> $past(wr_ctl) || $past(wr_ctl, 2))
      else $error("read timing changed without a control write");
   a_req_taken: assert property (acc_req && !acc_busy |=> acc_busy || access_miss)
      else $error("access request neither started nor missed");
   a_miss_quiet: assert property (access_miss |-> &chip_sel_n)
      else $error("chip select active on an internal access");
   a_width_excl: assert property (!(bus16 && bus8))
      else $error("both bus widths flagged");
   a_rdata_slot: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
      else $error("read data outside its slot");
   c_miss: cover property (access_miss);
   c_long_wait: cover property (&chip_sel_n && cnt_q == 4'h9);
   c_early: cover property (wr_ctl && reg_wdata[ebsc_rts_bit]);
endmodule // ebsc_top_monitor

bind ebsc_top ebsc_top_monitor u_mon (.clk(clk), .reset(reset), .boot_8bit(boot_8bit),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_busy(acc_busy), .chip_sel_n(chip_sel_n),
   .boot_remap_on(boot_remap_on), .read_early(read_early), .bus16(bus16), .bus8(bus8),
   .access_miss(access_miss));

// ---- test/ebsc_top_tb.sv ----
// Self-checking bench for the region select block
module ebsc_top_tb
   import ebsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [31:0] cfg; logic [31:0] addr; logic [3:0] len; logic [2:0] flg;} ebsc_row_t;
   logic clk = 1'b0, reset = 1'b1, boot_8bit = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic acc_req = 1'b0, acc_write = 1'b0, m;
   logic [7:0] reg_addr = 8'h00, chip_sel_n, sel_count;
   logic [31:0] reg_wdata = 32'h0, acc_addr = 32'h0, reg_rdata;
   logic acc_busy, boot_remap_on, read_early, bsm, bus16, bus8, access_miss;
   logic [2:0] last_rgn;
   logic [3:0] f;
   logic [3:0] last_len;
   int err_count = 0, comparisons = 0, cyc = 0, d;
   // Region n sits at base n so cfg[30:28] also names the register slot
   ebsc_row_t rows [4] = '{'{32'h1000_2001, 32'h1000_0040, 4'h1, 3'b010},
      '{32'h2050_30aa, 32'h2060_0000, 4'h4, 3'b101},
      '{32'h30f0_213d, 32'h30a0_0000, 4'h9, 3'b010},
      '{32'h43f0_2196, 32'h4200_0000, 4'h1, 3'b001}};
   ebsc_top dut (.clk(clk), .reset(reset), .boot_8bit(boot_8bit), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr), .acc_busy(acc_busy),
      .chip_sel_n(chip_sel_n), .boot_remap_on(boot_remap_on), .read_early(read_early),
      .byte_select_mode(bsm), .bus16(bus16), .bus8(bus8), .access_miss(access_miss));
   ebsc_mem_model u_mem (.clk(clk), .chip_sel_n(chip_sel_n), .last_rgn(last_rgn),
      .last_len(last_len), .sel_count(sel_count));
   always #10 clk = ~clk;
   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   // Bounded wait: a miss never lowers a select, so d stops at 12
   task automatic acc(input logic [31:0] a, output int d, output logic m, output logic [3:0] f);
      @(posedge clk);
      acc_req <= 1'b1;
      acc_addr <= a;
      @(posedge clk);
      acc_req <= 1'b0;
      #1 m = access_miss;
      d = 1;
      while (&chip_sel_n && d < 12) begin
         @(posedge clk);
         #1 d++;
      end
      // Busy is caught while the select stands, so a taken request shows up here
      f = {acc_busy, bsm, bus16, bus8};
      while (acc_busy) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
   endtask
   task automatic stop_test();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rdc(ebsc_off_region0, ebsc_region0_rst_8);
      foreach (rows[k]) begin
         wr({3'h0, rows[k].cfg[30:28], 2'h0}, rows[k].cfg);
         acc(rows[k].addr, d, m, f);
         check(d, 1);
         check(f, {1'b1, rows[k].flg});
         check(last_len, rows[k].len);
         check(last_rgn, rows[k].cfg[30:28]);
      end
      rdc(ebsc_off_remap, 32'h0);
      rdc(8'h28, 32'h0);
      wr(8'h14, 32'hffff_ffff);
      rdc(8'h14, ebsc_region_mask);
      wr(ebsc_off_memctl, 32'hffff_ffff);
      rdc(ebsc_off_memctl, ebsc_memctl_mask);
      check(read_early, 1'b1);
      wr(ebsc_off_memctl, 32'h0);
      rdc(ebsc_off_memctl, 32'h0);
      check(read_early, 1'b0);
      wr(ebsc_off_remap, 32'h0);
      check(boot_remap_on, 1'b1);
      wr(ebsc_off_remap, 32'h1);
      check(boot_remap_on, 1'b0);
      wr(8'h04, 32'h1000_0001);
      acc(32'h1000_0040, d, m, f);
      check(m, 1'b1);
      check(d, 12);
      wr(8'h08, 32'h2050_3eaa);
      acc(32'h2060_0000, d, m, f);
      acc(32'h2060_0000, d, m, f);
      check(d, 1);
      // A write to the same memory still waits out the float time left over
      @(posedge clk);
      acc_write <= 1'b1;
      acc(32'h2060_0000, d, m, f);
      check(d, 4);
      @(posedge clk);
      acc_write <= 1'b0;
      acc(32'h4200_0000, d, m, f);
      check(d > 1, 1'b1);
      @(posedge clk);
      boot_8bit <= 1'b0;
      reset <= 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      #1 check(chip_sel_n, 8'hff);
      check(boot_remap_on, 1'b1);
      for (int i = 0; i < 8; i++)
         rdc(8'(i * 4), i == 0 ? ebsc_region0_rst_16 : 32'(ebsc_region_rst_step * i));
      rdc(ebsc_off_memctl, ebsc_memctl_rst);
      stop_test();
   end
endmodule // ebsc_top_tb

// ---- verilog/ebsc_pkg.sv ----
// Package of register map, field layout and reset values for the external bus select config
package ebsc_pkg;
   localparam int unsigned ebsc_addr_w = 8;
   localparam int unsigned ebsc_regions = 8;
   localparam logic [7:0] ebsc_off_region0 = 8'h00;
   localparam logic [7:0] ebsc_off_remap = 8'h20;
   localparam logic [7:0] ebsc_off_memctl = 8'h24;
   localparam logic [7:0] ebsc_region_span = 8'h1c;
   // Region select field layout
   localparam int unsigned ebsc_bw_lo = 0;
   localparam int unsigned ebsc_wc_lo = 2;
   localparam int unsigned ebsc_wg_bit = 5;
   localparam int unsigned ebsc_ps_lo = 7;
   localparam int unsigned ebsc_fc_lo = 9;
   localparam int unsigned ebsc_bls_bit = 12;
   localparam int unsigned ebsc_so_bit = 13;
   localparam int unsigned ebsc_ba_lo = 20;
   localparam logic [31:0] ebsc_region_mask = 32'hfff0_3fbf;
   localparam int unsigned ebsc_undo_bit = 0;
   localparam int unsigned ebsc_rts_bit = 4;
   localparam logic [31:0] ebsc_memctl_mask = 32'h0000_0010;
   localparam logic [31:0] ebsc_memctl_rst = 32'h0000_0000;
   localparam logic [31:0] ebsc_region0_rst_8 = 32'h0000_203e;
   localparam logic [31:0] ebsc_region0_rst_16 = 32'h0000_203d;
   localparam logic [31:0] ebsc_region_rst_step = 32'h1000_0000;
   // Page size codes and base compare masks over address bits 31-20
   typedef enum logic [1:0] {
      ebsc_page_1m = 2'b00,
      ebsc_page_4m = 2'b01,
      ebsc_page_16m = 2'b10,
      ebsc_page_64m = 2'b11
   } ebsc_page_t;
   localparam logic [11:0] ebsc_cmp_1m = 12'hfff;
   localparam logic [11:0] ebsc_cmp_4m = 12'hffc;
   localparam logic [11:0] ebsc_cmp_16m = 12'hff0;
   localparam logic [11:0] ebsc_cmp_64m = 12'hfc0;
   localparam logic [1:0] ebsc_bw_16 = 2'b01;
   localparam logic [1:0] ebsc_bw_8 = 2'b10;
   localparam logic [3:0] ebsc_no_wait = 4'h0;
   localparam logic [3:0] ebsc_wait_one = 4'h1;
   localparam logic [2:0] ebsc_fc_zero = 3'h0;
   localparam logic [2:0] ebsc_region_none = 3'h0;
endpackage

// ---- verilog/ebsc_regmem.sv ----
// Eight-word region select register store with registered read data
module ebsc_regmem
   import ebsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic boot_8bit,
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [31:0] wr_data,
   input wire logic [2:0] rd_idx,
   output logic [31:0] rd_data_q,
   output logic [31:0] region_flat_q [ebsc_regions]
);
   logic [31:0] mem_d [ebsc_regions];
   logic [31:0] rd_data_d;

   // Synchronous reset loads documented defaults; region 0 width follows the boot strap
   always_comb begin
      for (int i = 0; i < ebsc_regions; i++) begin
         mem_d[i] = region_flat_q[i];
      end
      if (reset) begin
         mem_d[0] = boot_8bit ? ebsc_region0_rst_8 : ebsc_region0_rst_16;
         for (int i = 1; i < ebsc_regions; i++) begin
            mem_d[i] = 32'(ebsc_region_rst_step * 32'(i));
         end
      end else if (wr_en) begin
         mem_d[wr_idx] = wr_data & ebsc_region_mask;
      end
      rd_data_d = region_flat_q[rd_idx];
   end

   always_ff @(posedge clk) begin
      region_flat_q <= mem_d;
      rd_data_q <= rd_data_d;
   end
endmodule // ebsc_regmem

// ---- verilog/ebsc_top.sv ----
// Region select configuration, address decode and chip select sequencing
// What this block does
// - Wait-enable clear means no programmed wait states; set applies them.
// - Page code picks 1M/4M/16M/64M, comparing bits 31-20/22/24/26.
// - Base holds top address bits; bits inside a large page are ignored.
// - Float field adds 0 to 7 idle cycles after a transfer.
// - Byte style bit: 0 byte-write strobes, 1 byte-select strobes.
// - Chip select forced off from the clock after region select is turned off.
// - Writing 1 to remap bit 0 cancels boot remap; 0 does nothing.
// - Memory control bit 4: 0 standard read timing, 1 early read.
// - Wait code n gives n+1 wait states, only when wait-enable set.
// - Width code 01 is 16-bit, 10 is 8-bit; others reserved.
// - Float idles skip internal accesses and same-memory reads.
module ebsc_top
   import ebsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic boot_8bit,
   input wire logic [ebsc_addr_w-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic [31:0] acc_addr,
   output logic acc_busy,
   output logic [7:0] chip_sel_n,
   output logic boot_remap_on,
   output logic read_early,
   output logic byte_select_mode,
   output logic bus16,
   output logic bus8,
   output logic access_miss
);
   // ****************************************************************
   // Register access
   // ****************************************************************
   logic [31:0] region_q [ebsc_regions];
   logic [31:0] mem_rd;
   logic memctl_hit_q, region_hit_q, memctl_hit_d, region_hit_d;
   logic [31:0] memctl_q, memctl_d;
   logic remap_q, remap_d;
   logic region_wr;

   function automatic logic is_region(input logic [ebsc_addr_w-1:0] a);
      return (a[1:0] == 2'b00) && (a <= ebsc_region_span);
   endfunction

   // Page code to compare mask over address bits 31-20
   function automatic logic [11:0] page_mask(input logic [1:0] code);
      case (ebsc_page_t'(code))
         ebsc_page_1m: page_mask = ebsc_cmp_1m;
         ebsc_page_4m: page_mask = ebsc_cmp_4m;
         ebsc_page_16m: page_mask = ebsc_cmp_16m;
         ebsc_page_64m: page_mask = ebsc_cmp_64m;
         default: page_mask = ebsc_cmp_1m;
      endcase
   endfunction

   assign region_wr = reg_wr && is_region(reg_addr);

   ebsc_regmem u_mem (
      .clk(clk),
      .reset(reset),
      .boot_8bit(boot_8bit),
      .wr_en(region_wr),
      .wr_idx(reg_addr[4:2]),
      .wr_data(reg_wdata),
      .rd_idx(reg_addr[4:2]),
      .rd_data_q(mem_rd),
      .region_flat_q(region_q)
   );

   always_comb begin
      memctl_d = memctl_q;
      remap_d = remap_q;
      if (reg_wr && reg_addr == ebsc_off_memctl) begin
         memctl_d = reg_wdata & ebsc_memctl_mask;
      end
      // Remap can only be cancelled, never re-armed, until the next reset
      if (reg_wr && reg_addr == ebsc_off_remap && reg_wdata[ebsc_undo_bit]) begin
         remap_d = 1'b0;
      end
      region_hit_d = reg_rd && is_region(reg_addr);
      memctl_hit_d = reg_rd && reg_addr == ebsc_off_memctl;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         memctl_q <= ebsc_memctl_rst;
         remap_q <= 1'b1;
         region_hit_q <= 1'b0;
         memctl_hit_q <= 1'b0;
      end else begin
         memctl_q <= memctl_d;
         remap_q <= remap_d;
         region_hit_q <= region_hit_d;
         memctl_hit_q <= memctl_hit_d;
      end
   end

   // Read data; remap register is write-only and reads zero like any unmapped word
   assign reg_rdata = region_hit_q ? mem_rd : (memctl_hit_q ? memctl_q : 32'h0000_0000);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   logic [7:0] hit;
   logic [2:0] hit_idx;
   logic any_hit;
   logic [31:0] sel_cfg;

   always_comb begin
      hit = 8'h00;
      hit_idx = ebsc_region_none;
      any_hit = 1'b0;
      for (int i = 0; i < ebsc_regions; i++) begin
         logic [11:0] m;
         m = page_mask(region_q[i][ebsc_ps_lo +: 2]);
         // Lower base bits inside a large page are masked out
         if (region_q[i][ebsc_so_bit] &&
             ((acc_addr[31:20] & m) == (region_q[i][31:20] & m))) begin
            hit[i] = 1'b1;
         end
      end
      // Lowest region sets the timing if bases overlap; an access with no float gap still drives every matching select low
      for (int i = ebsc_regions - 1; i >= 0; i--) begin
         if (hit[i]) begin
            hit_idx = 3'(i);
            any_hit = 1'b1;
         end
      end
      sel_cfg = region_q[hit_idx];
   end

   // ****************************************************************
   // Access sequencer
   // ****************************************************************
   typedef enum logic [1:0] {
      ebsc_st_idle = 2'b00,
      ebsc_st_float = 2'b01,
      ebsc_st_access = 2'b10
   } ebsc_state_t;

   ebsc_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [2:0] float_q, float_d;
   logic [2:0] last_q, last_d;
   logic last_valid_q, last_valid_d;
   logic [2:0] cur_q, cur_d;
   logic pend_write_q, pend_write_d;
   logic [7:0] cs_n_q, cs_n_d;
   logic busy_q, busy_d;
   logic early_q, bsel_q, b16_q, b8_q, miss_q;
   logic bsel_d, b16_d, b8_d, miss_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      float_d = float_q;
      last_d = last_q;
      last_valid_d = last_valid_q;
      cur_d = cur_q;
      pend_write_d = pend_write_q;
      cs_n_d = cs_n_q;
      busy_d = busy_q;
      bsel_d = bsel_q;
      b16_d = b16_q;
      b8_d = b8_q;
      miss_d = 1'b0;
      case (state_q)
         ebsc_st_idle: begin
            cs_n_d = 8'hff;
            busy_d = 1'b0;
            // Float time keeps counting down during internal (miss) accesses
            if (float_q != ebsc_fc_zero) begin
               float_d = float_q - 3'h1;
            end
            if (acc_req && !any_hit) begin
               miss_d = 1'b1;
            end else if (acc_req) begin
               cur_d = hit_idx;
               pend_write_d = acc_write;
               busy_d = 1'b1;
               bsel_d = sel_cfg[ebsc_bls_bit];
               b16_d = sel_cfg[ebsc_bw_lo +: 2] == ebsc_bw_16;
               b8_d = sel_cfg[ebsc_bw_lo +: 2] == ebsc_bw_8;
               // Same memory back to back reads need no float gap
               if (float_q != ebsc_fc_zero && last_valid_q &&
                   (hit_idx != last_q || acc_write)) begin
                  state_d = ebsc_st_float;
               end else begin
                  state_d = ebsc_st_access;
                  cs_n_d = ~hit;
                  cnt_d = sel_cfg[ebsc_wg_bit] ?
                     4'(sel_cfg[ebsc_wc_lo +: 3]) + ebsc_wait_one : ebsc_no_wait;
               end
            end
         end
         ebsc_st_float: begin
            if (float_q <= 3'h1) begin
               float_d = ebsc_fc_zero;
               state_d = ebsc_st_access;
               cs_n_d = ~(8'h01 << cur_q);
               cnt_d = region_q[cur_q][ebsc_wg_bit] ?
                  4'(region_q[cur_q][ebsc_wc_lo +: 3]) + ebsc_wait_one : ebsc_no_wait;
            end else begin
               float_d = float_q - 3'h1;
            end
         end
         ebsc_st_access: begin
            if (cnt_q != ebsc_no_wait) begin
               cnt_d = cnt_q - ebsc_wait_one;
            end else begin
               state_d = ebsc_st_idle;
               cs_n_d = 8'hff;
               busy_d = 1'b0;
               last_d = cur_q;
               last_valid_d = 1'b1;
               float_d = region_q[cur_q][ebsc_fc_lo +: 3];
            end
         end
         default: begin
            state_d = ebsc_st_idle;
            cs_n_d = 8'hff;
         end
      endcase
      // Disabling a region drops its select on the following clock, even mid-access
      for (int i = 0; i < ebsc_regions; i++) begin
         if (!region_q[i][ebsc_so_bit]) begin
            cs_n_d[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ebsc_st_idle;
         cnt_q <= ebsc_no_wait;
         float_q <= ebsc_fc_zero;
         last_q <= ebsc_region_none;
         last_valid_q <= 1'b0;
         cur_q <= ebsc_region_none;
         pend_write_q <= 1'b0;
         cs_n_q <= 8'hff;
         busy_q <= 1'b0;
         early_q <= 1'b0;
         bsel_q <= 1'b0;
         b16_q <= 1'b0;
         b8_q <= 1'b0;
         miss_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         float_q <= float_d;
         last_q <= last_d;
         last_valid_q <= last_valid_d;
         cur_q <= cur_d;
         pend_write_q <= pend_write_d;
         cs_n_q <= cs_n_d;
         busy_q <= busy_d;
         early_q <= memctl_q[ebsc_rts_bit];
         bsel_q <= bsel_d;
         b16_q <= b16_d;
         b8_q <= b8_d;
         miss_q <= miss_d;
      end
   end

   assign chip_sel_n = cs_n_q;
   assign acc_busy = busy_q;
   assign boot_remap_on = remap_q;
   assign read_early = early_q;
   assign byte_select_mode = bsel_q;
   assign bus16 = b16_q;
   assign bus8 = b8_q;
   assign access_miss = miss_q;
endmodule // ebsc_top
